// ===== design/sdm_sequencer.sv
`timescale 1ns/100ps
module sdm_sequencer
   import sdm_pkg::*;
#(
   parameter int STST_CYCLES = SDM_STST_CYCLES
)
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic step_in,
   input wire logic dir_in,
   input wire logic [SDM_RES_W-1:0] res_sel,
   input wire logic power_down_select_pin,
   output logic [SDM_POS_W-1:0] microstep_position_count_r,
   output logic signed [SDM_AMP_W-1:0] coil_a_r,
   output logic signed [SDM_AMP_W-1:0] coil_b_r,
   output logic index_r,
   output logic standstill_r,
   output logic standby_req_r
);
   // -------------------------------------------------
   // input synchronisers
   // -------------------------------------------------
   logic step_s1_r;
   logic step_s2_r;
   logic step_s3_r;
   logic dir_s1_r;
   logic dir_s2_r;
   logic step_edge;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         step_s1_r <= 1'b0;
         step_s2_r <= 1'b0;
         step_s3_r <= 1'b0;
         dir_s1_r <= 1'b0;
         dir_s2_r <= 1'b0;
      end
      else
      begin
         step_s1_r <= step_in;
         step_s2_r <= step_s1_r;
         step_s3_r <= step_s2_r;
         dir_s1_r <= dir_in;
         dir_s2_r <= dir_s1_r;
      end
   end

   // falling edges are deliberately ignored
   assign step_edge = step_s2_r & ~step_s3_r;
   // -------------------------------------------------
   // resolution tracking
   // -------------------------------------------------
   logic [SDM_RES_W-1:0] res_r;
   logic [SDM_RES_W-1:0] res_eff;
   logic res_change;
   logic [SDM_POS_W-1:0] width;

   assign res_eff = (res_sel > SDM_RES_FULL) ? SDM_RES_FULL : res_sel;
   assign res_change = (res_eff != res_r);
   assign width = SDM_POS_W'(1) << res_r;

   function automatic logic [SDM_POS_W-1:0] snap(
      input logic [SDM_POS_W-1:0] pos,
      input logic [SDM_RES_W-1:0] res
   );
      logic [SDM_POS_W-1:0] w;
      w = SDM_POS_W'(1) << res;
      if (res == SDM_RES_RST)
         snap = pos;
      else
         snap = (pos & ~(w - SDM_POS_W'(1))) | (w >> 1);
   endfunction : snap

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         res_r <= SDM_RES_RST;
      else
         res_r <= res_eff;
   end
   // -------------------------------------------------
   // interval measurement and standstill
   // -------------------------------------------------
   logic [SDM_CNT_W-1:0] since_r;
   logic seen_r;
   logic at_limit;
   logic [SDM_CNT_W-1:0] per_div;

   assign at_limit = (since_r == SDM_CNT_W'(STST_CYCLES - 1));
   // since_r restarts at 0 on the edge, so the period is one more
   assign per_div = (since_r + SDM_CNT_W'(1)) >> res_r;

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         since_r <= '0;
      else if (step_edge)
         since_r <= '0;
      else if (!at_limit)
         since_r <= since_r + SDM_CNT_W'(1);
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         seen_r <= 1'b0;
      else if (step_edge)
         seen_r <= 1'b1;
   end
   // clear wins over set if both land together
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         standstill_r <= 1'b0;
      else if (at_limit && !step_edge)
         standstill_r <= 1'b1;
      else if (step_edge)
         standstill_r <= 1'b0;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         standby_req_r <= 1'b0;
      else
         standby_req_r <= standstill_r & power_down_select_pin;
   end
   // -------------------------------------------------
   // target position and interpolator
   // -------------------------------------------------
   sdm_ip_state_t state_r;
   logic [SDM_POS_W-1:0] target_r;
   logic [SDM_PEND_W-1:0] pend_r;
   logic [SDM_CNT_W-1:0] spacing_r;
   logic [SDM_CNT_W-1:0] tick_r;
   logic dir_r;
   logic interp_ok;
   logic tick_due;
   logic [SDM_POS_W-1:0] step_nxt;
   logic [SDM_POS_W-1:0] first_nxt;

   // a stale period after standstill would crawl, so jump instead
   assign interp_ok = seen_r & ~standstill_r;
   assign tick_due = (tick_r + SDM_CNT_W'(1) >= spacing_r);
   assign step_nxt = dir_s2_r ? target_r - width
                              : target_r + width;
   assign first_nxt = dir_s2_r ? target_r - SDM_POS_W'(1)
                               : target_r + SDM_POS_W'(1);

   // a pulse in a resolution-change cycle is dropped
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         target_r <= SDM_POS_RST;
      else if (res_change)
         target_r <= snap(target_r, res_eff);
      else if (step_edge)
         target_r <= step_nxt;
   end
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         state_r <= SDM_IDLE;
         pend_r <= '0;
         spacing_r <= SDM_CNT_W'(1);
         tick_r <= '0;
         dir_r <= 1'b0;
      end
      else if (res_change)
      begin
         state_r <= SDM_IDLE;
         pend_r <= '0;
         tick_r <= '0;
      end
      else if (step_edge)
      begin
         dir_r <= dir_s2_r;
         tick_r <= '0;
         spacing_r <= (per_div == '0) ? SDM_CNT_W'(1)
                                      : per_div;
         if (interp_ok && res_r != SDM_RES_RST)
         begin
            state_r <= SDM_RUN;
            pend_r <= SDM_PEND_W'(width - SDM_POS_W'(1));
         end
         else
         begin
            state_r <= SDM_IDLE;
            pend_r <= '0;
         end
      end
      else
      begin
         case (state_r)
            SDM_IDLE:
               tick_r <= '0;
            SDM_RUN:
            begin
               if (tick_due)
               begin
                  tick_r <= '0;
                  pend_r <= pend_r - SDM_PEND_W'(1);
                  if (pend_r == SDM_PEND_W'(1))
                     state_r <= SDM_IDLE;
               end
               else
                  tick_r <= tick_r + SDM_CNT_W'(1);
            end
            default:
               state_r <= SDM_IDLE;
         endcase
      end
   end
   // -------------------------------------------------
   // microstep position counter
   // -------------------------------------------------
   logic [SDM_POS_W-1:0] count_nxt;
   logic micro_step;
   assign micro_step = (state_r == SDM_RUN) && tick_due &&
                       !step_edge && !res_change;
   always_comb
   begin
      count_nxt = microstep_position_count_r;
      if (res_change)
         count_nxt = snap(target_r, res_eff);
      else if (step_edge && interp_ok && res_r != SDM_RES_RST)
         count_nxt = first_nxt;
      else if (step_edge)
         count_nxt = step_nxt;
      else if (micro_step && dir_r)
         count_nxt = microstep_position_count_r - SDM_POS_W'(1);
      else if (micro_step)
         count_nxt = microstep_position_count_r + SDM_POS_W'(1);
   end
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         microstep_position_count_r <= SDM_POS_RST;
      else
         microstep_position_count_r <= count_nxt;
   end
   // -------------------------------------------------
   // coil currents and index
   // -------------------------------------------------
   logic signed [SDM_AMP_W-1:0] sine_a;
   logic signed [SDM_AMP_W-1:0] sine_b;

   sdm_sine_rom #(.OFFSET(SDM_COIL_A_OFS)) u_rom_a
   (
      .phase(microstep_position_count_r),
      .value(sine_a)
   );
   sdm_sine_rom #(.OFFSET(SDM_COIL_B_OFS)) u_rom_b
   (
      .phase(microstep_position_count_r),
      .value(sine_b)
   );

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         coil_a_r <= '0;
         coil_b_r <= '0;
         index_r <= 1'b0;
      end
      else
      begin
         coil_a_r <= sine_a;
         coil_b_r <= sine_b;
         index_r <= (microstep_position_count_r == SDM_INDEX_POS);
      end
   end
   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   property p_fall_no_move;
      @(posedge sys_clk) disable iff (!rst_b)
      (state_r == SDM_IDLE && !step_edge && !res_change)
         |=> $stable(microstep_position_count_r);
   endproperty
   a_fall_no_move: assert property (p_fall_no_move)
      else $error("position moved without a rising pulse");
   property p_sync_edge;
      @(posedge sys_clk) disable iff (!rst_b)
      step_edge |-> $past(step_in, 2) && !$past(step_in, 3);
   endproperty
   a_sync_edge: assert property (p_sync_edge)
      else $error("pulse edge not from synchronised input");
   property p_dir_add_sub;
      @(posedge sys_clk) disable iff (!rst_b)
      (step_edge && !res_change) |=>
         target_r == ($past(dir_s2_r) ? $past(target_r) - $past(width)
                                     : $past(target_r) + $past(width));
   endproperty
   a_dir_add_sub: assert property (p_dir_add_sub)
      else $error("target did not move by step width");
   property p_grid;
      @(posedge sys_clk) disable iff (!rst_b)
      (res_r != SDM_RES_RST) |->
         (target_r & (width - SDM_POS_W'(1))) == (width >> 1);
   endproperty
   a_grid: assert property (p_grid)
      else $error("target off the resolution grid");
   property p_full_grid;
      @(posedge sys_clk) disable iff (!rst_b)
      (res_r == SDM_RES_FULL) |-> target_r[7:0] == 8'h80;
   endproperty
   a_full_grid: assert property (p_full_grid)
      else $error("full step position not on 128 grid");
   property p_interp_load;
      @(posedge sys_clk) disable iff (!rst_b)
      (step_edge && !res_change && interp_ok && res_r != SDM_RES_RST)
         |=> pend_r == SDM_PEND_W'($past(width) - SDM_POS_W'(1))
             && microstep_position_count_r == $past(first_nxt);
   endproperty
   a_interp_load: assert property (p_interp_load)
      else $error("interpolation not started correctly");
   property p_spacing;
      @(posedge sys_clk) disable iff (!rst_b)
      spacing_r != '0 && spacing_r <= SDM_CNT_W'(STST_CYCLES)
         && tick_r < spacing_r;
   endproperty
   a_spacing: assert property (p_spacing)
      else $error("microstep spacing out of range");
   property p_stst_set;
      @(posedge sys_clk) disable iff (!rst_b)
      (at_limit && !step_edge) |=> standstill_r ##1 
         (standby_req_r == $past(power_down_select_pin));
   endproperty
   a_stst_set: assert property (p_stst_set)
      else $error("standstill or standby not raised");
   property p_stst_clear;
      @(posedge sys_clk) disable iff (!rst_b)
      (step_edge && !at_limit) |=> !standstill_r;
   endproperty
   a_stst_clear: assert property (p_stst_clear)
      else $error("standstill not cleared by pulse");
   property p_wrap;
      @(posedge sys_clk) disable iff (!rst_b)
      (microstep_position_count_r == 10'h3ff && !res_change &&
       ((micro_step && !dir_r) ||
        (step_edge && res_r == SDM_RES_RST && !dir_s2_r)))
         |=> microstep_position_count_r == 10'h000;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("position did not wrap to zero");
   property p_index;
      @(posedge sys_clk) disable iff (!rst_b)
      (microstep_position_count_r == SDM_INDEX_POS) |=>
         index_r && coil_a_r == 9'sh000;
   endproperty
   a_index: assert property (p_index)
      else $error("index or coil A wrong at zero point");
   c_standstill: cover property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(standstill_r));
   c_interp_done: cover property (@(posedge sys_clk) disable iff (!rst_b)
      state_r == SDM_RUN ##1 state_r == SDM_IDLE);
   c_coarser: cover property (@(posedge sys_clk) disable iff (!rst_b)
      res_change && res_eff > res_r);
   c_index: cover property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(index_r));
endmodule : sdm_sequencer

// ===== design/sdm_sine_rom.sv
`timescale 1ns/100ps
module sdm_sine_rom
   import sdm_pkg::*;
#(
   parameter logic [SDM_POS_W-1:0] OFFSET = SDM_COIL_A_OFS
)
(
   input wire logic [SDM_POS_W-1:0] phase,
   output logic signed [SDM_AMP_W-1:0] value
);
   // -------------------------------------------------
   // quarter wave, 33 points, linear in between
   // -------------------------------------------------
   // coarse points trade a little accuracy for area
   localparam logic [7:0] SINE_PTS [0:32] = '{
      8'h00, 8'h0d, 8'h19, 8'h25, 8'h32, 8'h3e, 8'h4a, 8'h56,
      8'h62, 8'h6d, 8'h78, 8'h83, 8'h8e, 8'h98, 8'ha2, 8'hab,
      8'hb4, 8'hbd, 8'hc5, 8'hcd, 8'hd4, 8'hdb, 8'he1, 8'he7,
      8'hec, 8'hf0, 8'hf4, 8'hf7, 8'hfa, 8'hfc, 8'hfe, 8'hff,
      8'hff};

   logic [SDM_POS_W-1:0] ph;
   logic [8:0] q;
   logic [5:0] idx;
   logic [5:0] idx_hi;
   logic [7:0] lo;
   logic [7:0] hi;
   logic [10:0] prod;
   logic [7:0] mag;

   always_comb
   begin
      ph = phase + OFFSET;
      if (ph[8])
         q = SDM_QUARTER_LEN - {1'b0, ph[7:0]};
      else
         q = {1'b0, ph[7:0]};
      idx = q[8:3];
      idx_hi = (idx == 6'h20) ? idx : idx + 6'h01;
      lo = SINE_PTS[idx];
      hi = SINE_PTS[idx_hi];
      prod = 11'(hi - lo) * 11'(q[2:0]);
      mag = lo + 8'(prod >> 3);
      if (ph[9])
         value = -$signed({1'b0, mag});
      else
         value = $signed({1'b0, mag});
   end
endmodule : sdm_sine_rom

// ===== pkg/sdm_pkg.sv
// Notes on behaviour
// - only rising pulse edges move the sequencer
// - pulse and sense inputs synchronised before use
// - 1024-entry sine table, four full steps; code interpolates a 33-point quarter wave
// - sense low adds, sense high subtracts
// - step width doubles per coarser resolution
// - coarser resolution snaps to nearest valid position
// - full step uses 128 plus multiples of 256
// - half step uses 64 plus multiples of 128
// - quarter step uses 32 plus multiples of 64
// - interpolator emits single microsteps per pulse
// - last period split into equal sub-intervals
// - microstep spacing bounded by 2^20 cycles
// - no pulse within limit declares standstill
// - standstill starts standby only when pin enables
// - standstill flag cleared by next pulse edge
// - new rate adopted after one period; skips allowed
// - index active at electrical zero point
// - position count wraps 1023 to 0 and back
package sdm_pkg;
   // -------------------------------------------------
   // table geometry
   // -------------------------------------------------
   localparam int SDM_POS_W = 10;
   localparam int SDM_AMP_W = 9;
   localparam logic [9:0] SDM_COIL_A_OFS = 10'h000;
   localparam logic [9:0] SDM_COIL_B_OFS = 10'h100;
   localparam logic [9:0] SDM_INDEX_POS = 10'h000;
   localparam logic [8:0] SDM_QUARTER_LEN = 9'h100;
   // -------------------------------------------------
   // resolution coding: step width is 2**res
   // -------------------------------------------------
   localparam int SDM_RES_W = 4;
   localparam logic [3:0] SDM_RES_FULL = 4'h8;
   localparam logic [3:0] SDM_RES_RST = 4'h0;
   localparam logic [9:0] SDM_POS_RST = 10'h000;
   // -------------------------------------------------
   // interval timing, in sys_clk cycles
   // -------------------------------------------------
   localparam int SDM_STST_CYCLES = 1048576;
   localparam int SDM_CNT_W = 21;
   localparam int SDM_PEND_W = 9;
   typedef enum logic {SDM_IDLE, SDM_RUN} sdm_ip_state_t;
endpackage : sdm_pkg

// ===== test/sdm_step_ctrl.sv
`timescale 1ns/100ps
// ------------------------------------------------
// step/dir controller model
// ------------------------------------------------
module sdm_step_ctrl
(
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic [7:0] period,
   input wire logic dir_req,
   output logic step_r,
   output logic dir_r,
   output logic [15:0] edges_r
);
   logic [7:0] cnt_r;
   logic [7:0] per;
   logic step_nxt;
   // floor of 6 keeps high, low and dir setup at two clocks or more
   assign per = (period < 8'h06) ? 8'h06 : period;
   assign step_nxt = run && cnt_r >= 8'h02 && cnt_r < 8'h02 + (per >> 1);
   // fixed period while running, no jitter
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b || !run)
         cnt_r <= 8'h00;
      else if (cnt_r >= per - 8'h01)
         cnt_r <= 8'h00;
      else
         cnt_r <= cnt_r + 8'h01;
   end
   // dir changes only at period start, two clocks before the rise
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         dir_r <= 1'b0;
      else if (cnt_r == 8'h00)
         dir_r <= dir_req;
   end
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         step_r <= 1'b0;
      else
         step_r <= step_nxt;
   end
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
         edges_r <= 16'h0000;
      else if (step_nxt && !step_r)
         edges_r <= edges_r + 16'h0001;
   end
endmodule : sdm_step_ctrl

// ===== test/tb_step_dir_microstep_sequencer.sv
`timescale 1ns/100ps
// ------------------------------------------------
// bench for the step/dir sequencer
// ------------------------------------------------
module tb_step_dir_microstep_sequencer;
   // short standstill limit keeps the run brief
   localparam int STST = 64;
   logic sys_clk;
   logic rst_b;
   logic [3:0] res_sel;
   logic pd_sel;
   logic run;
   logic [7:0] period;
   logic dir_req;
   logic step_in;
   logic dir_in;
   logic [15:0] edges;
   logic [9:0] pos;
   logic signed [8:0] coil_a;
   logic signed [8:0] coil_b;
   logic index;
   logic stst;
   logic stby;
   logic mon_on;
   logic [9:0] last_pos;
   logic [9:0] exp_pos;
   int bad_count;
   int checked;
   int cyc;
   int changes;
   int min_gap;
   int last_t;
   sdm_sequencer #(.STST_CYCLES(STST)) sdm_sequencer_inst (
      .sys_clk(sys_clk), .rst_b(rst_b), .step_in(step_in),
      .dir_in(dir_in), .res_sel(res_sel), .power_down_select_pin(pd_sel),
      .microstep_position_count_r(pos), .coil_a_r(coil_a),
      .coil_b_r(coil_b), .index_r(index), .standstill_r(stst),
      .standby_req_r(stby));
   sdm_step_ctrl sdm_step_ctrl_inst (
      .sys_clk(sys_clk), .rst_b(rst_b), .run(run), .period(period),
      .dir_req(dir_req), .step_r(step_in), .dir_r(dir_in),
      .edges_r(edges));
   always #2.5 sys_clk = ~sys_clk;
   // ------------------------------------------------
   // monitor and timeout
   // ------------------------------------------------
   always @(posedge sys_clk)
   begin
      cyc++;
      if (mon_on && pos !== last_pos)
      begin
         changes++;
         if (changes > 1 && cyc - last_t < min_gap)
            min_gap = cyc - last_t;
         last_t = cyc;
      end
      last_pos <= pos;
      if (cyc == 20000)
      begin
         bad_count++;
         end_of_test();
      end
   end
   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick
   task automatic check_pos(input string what, input logic [9:0] e,
                            input logic [9:0] g);
      checked++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %0d seen %0d", what, e, g);
         bad_count++;
      end
   endtask : check_pos
   task automatic check_bit(input string what, input logic e,
                            input logic g);
      checked++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %b seen %b", what, e, g);
         bad_count++;
      end
   endtask : check_bit
   task automatic check_amp(input string what, input logic signed [8:0] e,
                            input logic signed [8:0] g);
      checked++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %0d seen %0d", what, e, g);
         bad_count++;
      end
   endtask : check_amp
   task automatic check_num(input string what, input int e, input int g);
      checked++;
      if (g != e)
      begin
         $display("MISMATCH %s expected %0d seen %0d", what, e, g);
         bad_count++;
      end
   endtask : check_num
   function automatic logic [9:0] snap(input logic [9:0] p, input int r);
      logic [9:0] w;
      w = 10'h001 << r;
      return (p & ~(w - 10'h001)) | (w >> 1);
   endfunction : snap
   task automatic pulses(input int n, input logic [7:0] per, input logic d);
      int tgt;
      tgt = edges + n;
      period <= per;
      dir_req <= d;
      run <= 1'b1;
      while (edges != tgt)
         @(posedge sys_clk);
      run <= 1'b0;
      tick(per + 12);
   endtask : pulses
   task automatic set_res(input logic [3:0] r);
      res_sel <= r;
      tick(4);
      exp_pos = snap(exp_pos, r);
      check_pos("snapped position", exp_pos, pos);
   endtask : set_res
   task automatic end_of_test();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_of_test
   // ------------------------------------------------
   // scenarios
   // ------------------------------------------------
   task automatic t_reset();
      check_pos("reset position", 10'h000, pos);
      check_amp("coil a at zero", 9'sh000, coil_a);
      check_amp("coil b at zero", 9'sh0ff, coil_b);
      check_bit("index at zero", 1'b1, index);
      check_bit("standstill", 1'b0, stst);
      check_bit("standby", 1'b0, stby);
   endtask : t_reset
   task automatic t_fine();
      pulses(3, 8'h06, 1'b0);
      check_pos("three up", 10'h003, pos);
      check_bit("index off zero", 1'b0, index);
      pulses(5, 8'h06, 1'b1);
      check_pos("wrap down", 10'h3fe, pos);
      pulses(2, 8'h06, 1'b0);
      check_pos("wrap up", 10'h000, pos);
      check_bit("index back", 1'b1, index);
      exp_pos = 10'h000;
   endtask : t_fine
   task automatic t_stst(input logic p);
      pd_sel <= p;
      tick(STST + 6);
      check_bit("standstill set", 1'b1, stst);
      check_bit("standby follows pin", p, stby);
      pulses(1, 8'h06, 1'b0);
      exp_pos = exp_pos + 10'h001;
      check_bit("standstill cleared", 1'b0, stst);
      check_bit("standby cleared", 1'b0, stby);
      check_pos("pulse after standstill", exp_pos, pos);
   endtask : t_stst
   task automatic t_res();
      set_res(4'h8);
      repeat (4)
      begin
         // full step pulses no faster than one per 512 clocks
         tick(512);
         pulses(1, 8'h06, 1'b0);
         exp_pos = exp_pos + 10'h100;
         check_pos("full step", exp_pos, pos);
         check_amp("equal coils", exp_pos[8] ? -coil_a : coil_a,
                   coil_b);
      end
      set_res(4'h7);
      set_res(4'h6);
   endtask : t_res
   task automatic t_interp();
      set_res(4'h2);
      tick(STST + 6);
      changes = 0;
      min_gap = 1000;
      mon_on = 1'b1;
      pulses(3, 8'h28, 1'b0);
      mon_on = 1'b0;
      exp_pos = exp_pos + 10'h00c;
      check_pos("interpolated end", exp_pos, pos);
      check_num("position changes", 9, changes);
      check_num("microstep spacing", 10, min_gap);
   endtask : t_interp
   task automatic t_rate();
      int tgt;
      tick(STST + 6);
      tgt = edges + 4;
      period <= 8'h28;
      dir_req <= 1'b1;
      run <= 1'b1;
      while (edges != tgt)
         @(posedge sys_clk);
      period <= 8'h14;
      tgt = tgt + 4;
      while (edges != tgt)
         @(posedge sys_clk);
      run <= 1'b0;
      tick(40);
      exp_pos = exp_pos - 10'h020;
      check_pos("after rate change", exp_pos, pos);
   endtask : t_rate
   initial
   begin
      sys_clk = 1'b0;
      rst_b = 1'b0;
      res_sel = 4'h0;
      pd_sel = 1'b0;
      run = 1'b0;
      period = 8'h06;
      dir_req = 1'b0;
      mon_on = 1'b0;
      exp_pos = 10'h000;
      bad_count = 0;
      checked = 0;
      cyc = 0;
      changes = 0;
      min_gap = 1000;
      last_t = 0;
      tick(2);
      rst_b <= 1'b1;
      tick(3);
      t_reset();
      t_fine();
      t_stst(1'b0);
      t_stst(1'b1);
      t_res();
      t_interp();
      t_rate();
      end_of_test();
   end
endmodule : tb_step_dir_microstep_sequencer
